/* File: rtis_pkg.sv */
// rtis_pkg: constants and carrier types for the serial target port
// assumes: one 100 MHz system clock; bus pins sampled inside the core
package rtis_pkg;

    // ----------------------------------------------------------------
    // bus constants
    // ----------------------------------------------------------------
    localparam logic [6:0] RTIS_TARGET_ADDR = 7'h68;
    localparam logic [2:0] RTIS_LAST_BIT = 3'h7;
    localparam logic [2:0] RTIS_BIT_ZERO = 3'h0;
    localparam int RTIS_ADDR_W = 8;
    localparam int RTIS_DATA_W = 8;
    localparam logic [7:0] RTIS_ADDR_RESET = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    // one open-drain pin: output level is always low, enable pulls it
    typedef struct packed {
        logic drive_low;
    } rtis_od_t;

    // user-side memory port
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtis_mem_req_t;

    // open-drain side pins toward the bus
    typedef struct packed {
        logic sda_oe;
        logic scl_oe;
        logic alert_oe;
        logic reset_oe;
    } rtis_pins_t;

endpackage : rtis_pkg

/* File: rtis_target.sv */
// rtis_target: serial two-wire target port with a byte memory behind it
// assumes: scl/sda arrive asynchronously from pins with external pull-ups;
// memory storage is flip-flops indexed by the address counter
`timescale 1ns/1ps
module rtis_target #(
    parameter int ADDR_W = rtis_pkg::RTIS_ADDR_W,
    parameter int DATA_W = rtis_pkg::RTIS_DATA_W
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic alert_request_in,
    input wire logic reset_request_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic scl_out,
    output logic scl_oe_out,
    output logic alert_or_square_wave_out,
    output logic alert_or_square_wave_oe_out,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    output rtis_pkg::rtis_mem_req_t mem_write_out,
    output logic [7:0] addr_counter_out
);
    import rtis_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_width
        $error("rtis_target supports 8-bit address and data only");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } rtis_phase_t;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [2:0] alert_sync;
        logic [2:0] rst_sync;
        logic scl_q;
        logic sda_q;
        rtis_phase_t phase;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic have_maddr;
        logic seen_rise;
        logic [7:0] addr_cnt;
        logic sda_low;
        logic alert_low;
        logic rst_low;
        rtis_mem_req_t mem_req;
    } rtis_state_t;

    rtis_state_t state;
    rtis_state_t next_state;
    logic [7:0] mem [0:255];
    logic [7:0] rd_byte;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // filtered level: changes only when stages two and three agree
    function automatic logic settle(input logic [2:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[2] : prev;
    endfunction : settle

    function automatic logic [7:0] bump(input logic [7:0] a);
        bump = a + 8'h01;
    endfunction : bump

    // upper seven bits against the fixed target; r/w bit ignored
    function automatic logic addr_hit(input logic [7:0] b);
        addr_hit = (b[7:1] == RTIS_TARGET_ADDR);
    endfunction : addr_hit

    assign rd_byte = mem[state.addr_cnt];

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic scl_f;
        logic sda_f;
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic byte_end;
        logic [7:0] sh;
        byte_end = 1'b0;
        scl_f = 1'b1;
        sda_f = 1'b1;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        sh = 8'h00;
        next_state = state;
        next_state.scl_sync = {state.scl_sync[1:0], scl_in};
        next_state.sda_sync = {state.sda_sync[1:0], sda_in};
        next_state.alert_sync = {state.alert_sync[1:0], alert_request_in};
        next_state.rst_sync = {state.rst_sync[1:0], reset_request_in};
        scl_f = settle(state.scl_sync, state.scl_q);
        sda_f = settle(state.sda_sync, state.sda_q);
        next_state.scl_q = scl_f;
        next_state.sda_q = sda_f;
        scl_rise = scl_f && !state.scl_q;
        scl_fall = !scl_f && state.scl_q;
        start_c = state.scl_q && scl_f && state.sda_q && !sda_f;
        stop_c = state.scl_q && scl_f && !state.sda_q && sda_f;
        next_state.mem_req.we = 1'b0;
        next_state.alert_low = settle(state.alert_sync, state.alert_low);
        next_state.rst_low = settle(state.rst_sync, state.rst_low);
        sh = {state.shift[6:0], sda_f};
        // eighth bit done: only after a rise, so the fall that closes
        // a start never looks like the end of a byte
        byte_end = scl_fall && state.bit_cnt == RTIS_BIT_ZERO && state.seen_rise;

        if (start_c) begin
            next_state.phase = ST_ADDR;
            next_state.bit_cnt = RTIS_BIT_ZERO;
            next_state.seen_rise = 1'b0;
            next_state.shift = 8'h00;
            next_state.have_maddr = 1'b0;
            next_state.sda_low = 1'b0;
        end else if (stop_c) begin
            next_state.phase = ST_IDLE;
            next_state.sda_low = 1'b0;
        end else begin
            case (state.phase)
                ST_IDLE: begin
                    next_state.sda_low = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_state.shift = sh;
                        next_state.bit_cnt = state.bit_cnt + 3'h1;
                        next_state.seen_rise = 1'b1;
                    end
                    if (byte_end) begin
                        next_state.seen_rise = 1'b0;
                        if (addr_hit(state.shift)) begin
                            next_state.sda_low = 1'b1;
                            next_state.phase = ST_ADDR_ACK;
                        end else begin
                            // not ours: stay silent until the next start
                            next_state.phase = ST_IDLE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (scl_rise) begin
                        next_state.shift = sh;
                        next_state.bit_cnt = state.bit_cnt + 3'h1;
                        next_state.seen_rise = 1'b1;
                    end
                    if (byte_end) begin
                        next_state.seen_rise = 1'b0;
                        next_state.sda_low = 1'b1;
                        next_state.phase = ST_WRITE_ACK;
                        if (!state.have_maddr) begin
                            next_state.addr_cnt = state.shift;
                            next_state.have_maddr = 1'b1;
                        end else begin
                            next_state.mem_req.we = 1'b1;
                            next_state.mem_req.addr = state.addr_cnt;
                            next_state.mem_req.wdata = state.shift;
                            next_state.addr_cnt = bump(state.addr_cnt);
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_state.bit_cnt = RTIS_BIT_ZERO;
                        if (state.shift[0]) begin
                            next_state.phase = ST_READ;
                            next_state.shift = rd_byte;
                            next_state.sda_low = !rd_byte[7];
                        end else begin
                            next_state.phase = ST_WRITE;
                            next_state.sda_low = 1'b0;
                        end
                    end
                end
                ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        next_state.phase = ST_WRITE;
                        next_state.bit_cnt = RTIS_BIT_ZERO;
                        next_state.sda_low = 1'b0;
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        next_state.bit_cnt = state.bit_cnt + 3'h1;
                        next_state.shift = {state.shift[6:0], 1'b0};
                        if (state.bit_cnt == RTIS_LAST_BIT) begin
                            next_state.phase = ST_READ_ACK;
                            next_state.sda_low = 1'b0;
                            next_state.addr_cnt = bump(state.addr_cnt);
                        end else begin
                            next_state.sda_low = !state.shift[6];
                        end
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise) begin
                        next_state.shift[0] = sda_f;
                    end
                    if (scl_fall) begin
                        next_state.bit_cnt = RTIS_BIT_ZERO;
                        if (!state.shift[0]) begin
                            next_state.phase = ST_READ;
                            next_state.shift = rd_byte;
                            next_state.sda_low = !rd_byte[7];
                        end else begin
                            next_state.phase = ST_IDLE;
                            next_state.sda_low = 1'b0;
                        end
                    end
                end
                default: begin
                    next_state.phase = ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= '0;
            state.scl_sync <= 3'h7;
            state.sda_sync <= 3'h7;
            state.scl_q <= 1'b1;
            state.sda_q <= 1'b1;
            state.phase <= ST_IDLE;
            state.addr_cnt <= RTIS_ADDR_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // byte storage
    // ----------------------------------------------------------------
    // unreset on purpose: contents are undefined until written
    always_ff @(posedge clk_in) begin
        if (next_state.mem_req.we) begin
            mem[next_state.mem_req.addr] <= next_state.mem_req.wdata;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb begin
        sda_out = 1'b0;
        sda_oe_out = state.sda_low;
        scl_out = 1'b0;
        scl_oe_out = 1'b0;
        alert_or_square_wave_out = 1'b0;
        alert_or_square_wave_oe_out = state.alert_low;
        reset_pin_out = 1'b0;
        reset_pin_oe_out = state.rst_low;
        mem_write_out = state.mem_req;
        addr_counter_out = state.addr_cnt;
    end

endmodule : rtis_target

/* File: rtis_checker.sv */
// rtis_checker: port-level assertions for the serial target port
// assumes: bound to rtis_target; single clock domain
`timescale 1ns/1ps
module rtis_checker (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic alert_request_in,
    input wire logic reset_request_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic alert_or_square_wave_out,
    input wire logic alert_or_square_wave_oe_out,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_out,
    input wire rtis_pkg::rtis_mem_req_t mem_write_out,
    input wire logic [7:0] addr_counter_out
);
    import rtis_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    logic [7:0] exp_cnt;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            exp_cnt <= 8'h00;
        end else if (mem_write_out.we) begin
            exp_cnt <= mem_write_out.addr + 8'h01;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_alert_on; ##[1:8] alert_or_square_wave_oe_out; endsequence
    sequence s_reset_on; ##[1:8] reset_pin_oe_out; endsequence
    no_stretch_a: assert property (!scl_oe_out)
        else $error("clock line pulled by target");
    sda_low_only_a: assert property (sda_oe_out |-> !sda_out)
        else $error("data line driven high");
    alert_low_only_a: assert property (alert_or_square_wave_oe_out |-> !alert_or_square_wave_out)
        else $error("alert pin driven high");
    rst_low_only_a: assert property (reset_pin_oe_out |-> !reset_pin_out)
        else $error("reset pin driven high");
    alert_follow_a: assert property ($rose(alert_request_in) |-> s_alert_on)
        else $error("alert pin not pulled");
    rst_follow_a: assert property ($rose(reset_request_in) |-> s_reset_on)
        else $error("reset pin not pulled");
    write_step_a: assert property (mem_write_out.we |=> ##[0:1] addr_counter_out == exp_cnt)
        else $error("counter not advanced after write");
    write_pulse_a: assert property (mem_write_out.we |=> !mem_write_out.we)
        else $error("write strobe longer than one cycle");
    sda_settle_a: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data line changed while clock high");
endmodule : rtis_checker

bind rtis_target rtis_checker i_rtis_checker (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in),
    .sda_in(sda_in), .alert_request_in(alert_request_in), .reset_request_in(reset_request_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .alert_or_square_wave_out(alert_or_square_wave_out), .alert_or_square_wave_oe_out(alert_or_square_wave_oe_out),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out), .mem_write_out(mem_write_out),
    .addr_counter_out(addr_counter_out));

/* File: rtis_master.sv */
// rtis_master: behavioural two-wire bus master
// assumes: sda_in is the resolved line; released data reads high
`timescale 1ns/1ps
module rtis_master (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // ------------------------------------------------------------
    // bus tasks, quarter bit of 8 clocks
    // ------------------------------------------------------------
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic q_wait();
        repeat (8) @(posedge clk_in);
    endtask : q_wait
    task automatic bit_io(input logic b, output logic r);
        sda_out <= b;
        q_wait();
        scl_out <= 1'b1;
        q_wait();
        r = sda_in;
        q_wait();
        scl_out <= 1'b0;
        q_wait();
    endtask : bit_io
    task automatic start();
        sda_out <= 1'b1;
        q_wait();
        scl_out <= 1'b1;
        q_wait();
        sda_out <= 1'b0;
        q_wait();
        scl_out <= 1'b0;
        q_wait();
    endtask : start
    task automatic stop();
        sda_out <= 1'b0;
        q_wait();
        scl_out <= 1'b1;
        q_wait();
        sda_out <= 1'b1;
        q_wait();
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!more, r);
    endtask : rd_byte
endmodule : rtis_master

/* File: testbench.sv */
// testbench: drives the target through the bus master model
// assumes: pull-ups on both bus lines; no stretching by the target
`timescale 1ns/1ps
module testbench;
    import rtis_pkg::*;
    typedef struct packed { logic [7:0] addr; logic [7:0] data; logic [7:0] cnt; } rtis_row_t;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk_in, reset_n_in, alert_request_in, reset_request_in, m_scl, m_sda, sda_bus, scl_bus;
    logic t_sda, t_sda_oe, t_scl, t_scl_oe, t_alert, t_alert_oe, t_rst, t_rst_oe;
    logic [7:0] addr_cnt;
    rtis_mem_req_t mem_wr, last_wr;
    int wr_cnt = 0, n, num_checks = 0, miscompares = 0;
    rtis_row_t rows [4] = '{'{8'h00, 8'h5a, 8'h01}, '{8'h14, 8'ha5, 8'h15}, '{8'h7f, 8'h01, 8'h80},
        '{8'hff, 8'h80, 8'h00}};
    logic [7:0] burst [3] = '{8'h11, 8'h22, 8'h33};
    logic [7:0] bad [4] = '{8'hd2, 8'h50, 8'h0b, 8'hd3};
    assign sda_bus = m_sda & ~t_sda_oe;
    assign scl_bus = m_scl & ~t_scl_oe;
    rtis_master i_rtis_master (.clk_in(clk_in), .sda_in(sda_bus), .scl_out(m_scl), .sda_out(m_sda));
    rtis_target i_rtis_target (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_bus), .sda_in(sda_bus),
        .alert_request_in(alert_request_in), .reset_request_in(reset_request_in), .sda_out(t_sda),
        .sda_oe_out(t_sda_oe), .scl_out(t_scl), .scl_oe_out(t_scl_oe), .alert_or_square_wave_out(t_alert),
        .alert_or_square_wave_oe_out(t_alert_oe), .reset_pin_out(t_rst), .reset_pin_oe_out(t_rst_oe),
        .mem_write_out(mem_wr), .addr_counter_out(addr_cnt));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (mem_wr.we === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wr <= mem_wr;
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic a;
        i_rtis_master.wr_byte(b, a);
        chk(24'(a), 24'(exp_ack));
    endtask : put
    task automatic get(input logic more, input logic [7:0] exp);
        logic [7:0] d;
        i_rtis_master.rd_byte(more, d);
        chk(24'(d), 24'(exp));
    endtask : get
    task automatic begin_wr(input logic [7:0] a);
        i_rtis_master.start();
        put(8'hd0, 1'b1);
        put(a, 1'b1);
    endtask : begin_wr
    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (60000) @(posedge clk_in);
        miscompares++;
        final_report();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n_in = 1'b0;
        alert_request_in = 1'b0;
        reset_request_in = 1'b0;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk({addr_cnt, 11'h000, t_sda_oe, t_scl_oe, t_alert_oe, t_rst_oe, mem_wr.we}, 24'h00_0000);
        foreach (rows[i]) begin
            n = wr_cnt;
            begin_wr(rows[i].addr);
            put(rows[i].data, 1'b1);
            i_rtis_master.stop();
            chk({8'(wr_cnt - n), last_wr.addr, last_wr.wdata}, {8'h01, rows[i].addr, rows[i].data});
            chk(24'(addr_cnt), 24'(rows[i].cnt));
            begin_wr(rows[i].addr);
            i_rtis_master.start();
            put(8'hd1, 1'b1);
            get(1'b0, rows[i].data);
            i_rtis_master.stop();
            chk(24'(addr_cnt), 24'(rows[i].cnt));
        end
        i_rtis_master.start();
        put(8'hd1, 1'b1);
        get(1'b0, rows[0].data);
        i_rtis_master.stop();
        n = wr_cnt;
        begin_wr(8'hfe);
        foreach (burst[k]) begin
            put(burst[k], 1'b1);
        end
        i_rtis_master.stop();
        chk(24'(wr_cnt - n), 24'h00_0003);
        chk(24'(addr_cnt), 24'h00_0001);
        begin_wr(8'hfe);
        i_rtis_master.start();
        put(8'hd1, 1'b1);
        foreach (burst[k]) begin
            get(k < 2, burst[k]);
        end
        chk(24'(t_sda_oe), 24'h00_0000);
        i_rtis_master.stop();
        n = wr_cnt;
        foreach (bad[k]) begin
            i_rtis_master.start();
            put(bad[k], 1'b0);
            put(8'h00, 1'b0);
            i_rtis_master.stop();
        end
        chk({8'(wr_cnt - n), addr_cnt}, 16'h0001);
        {alert_request_in, reset_request_in} <= 2'b10;
        repeat (10) @(posedge clk_in);
        chk({t_alert_oe, t_rst_oe, t_alert}, 24'h00_0004);
        {alert_request_in, reset_request_in} <= 2'b01;
        repeat (10) @(posedge clk_in);
        chk({t_alert_oe, t_rst_oe, t_rst}, 24'h00_0002);
        final_report();
    end
endmodule : testbench
